/* pkg/dca_pkg.sv */
// constants and types for the dual channel converter control block
// Operation
// [RQ1] both channels are sampled at the same instant once per convert period.
// [RQ2] the convert clock starts conversion and the system clock times it.
// [RQ3] each channel resolves 18 bits, one bit per approximation step.
// [RQ4] one conversion takes at least 64 system clocks per convert period.
// [RQ5] the host keeps the system clock at or below 6.144 MHz (96 KHz rate).
// [RQ6] a stored correction factor is added to every result automatically.
// [RQ7] results are loaded into shift registers and sent on one serial pin.
// [RQ8] output samples are two's complement.
// [RQ9] sequencing and output bit timing follow the system clock.
// [RQ10] the host should make the convert clock as system clock over 64.
// [RQ11] results of one convert period are shifted out in the next one.
// [RQ12] phase select high sends channel 1 on convert low, channel 2 on high.
// [RQ13] width select high sends 18-bit words, low sends 16-bit words.
// [RQ14] at clock over 64 the convert edge lands just after the lsb; the code sends the 18-bit lsb 14 clocks before the next edge.
// [RQ15] one bit per system clock, msb first, no gaps within a word.
`default_nettype none
package dca_pkg;
  localparam int unsigned RES_W = 18;
  localparam int unsigned NARROW_W = 16;
  localparam int unsigned CNT_W = 5;
  localparam logic [CNT_W-1:0] RES_LAST = 5'h11;
  localparam logic [CNT_W-1:0] NARROW_LAST = 5'h0f;
  localparam int unsigned CONVERT_CLOCK_MIN_CYC = 64;
  localparam logic [RES_W-1:0] CORR_RST = 18'h00000;
  localparam logic [RES_W-1:0] CORR_DEFAULT = 18'h00000;
  typedef enum logic [1:0] {DCA_IDLE, DCA_RUN, DCA_DONE} dca_state_t;
endpackage
`default_nettype wire

/* rtl/dca_sar.sv */
// one channel successive approximation register with correction add
`default_nettype none
module dca_sar
  import dca_pkg::*;
(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // control
  input wire logic i_start,
  input wire logic i_cmp_hi,
  input wire logic [RES_W-1:0] i_corr,
  // results
  output logic [RES_W-1:0] o_trial,
  output logic o_done,
  output logic [RES_W-1:0] o_result
);
  typedef struct packed {
    dca_state_t st;
    logic [RES_W-1:0] sar;
    logic [CNT_W-1:0] bit_idx;
    logic [RES_W-1:0] res;
    logic done;
  } dca_sar_st_t;
  dca_sar_st_t s_q, s_d;

  assign o_trial = s_q.sar;
  assign o_done = s_q.done;
  assign o_result = s_q.res;

  //////////////////////////////////////////////////////////////////////////
  // one bit per step from msb down, then correct
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    unique case (s_q.st)
      DCA_IDLE: begin
        if (i_start) begin
          s_d.st = DCA_RUN;
          s_d.bit_idx = RES_LAST;
          s_d.sar = {1'b1, {(RES_W-1){1'b0}}}; // [RQ3]
        end
      end
      DCA_RUN: begin
        // keep trial bit when input is above level, then try the next
        if (!i_cmp_hi) begin
          s_d.sar[s_q.bit_idx] = 1'b0; // [RQ3]
        end
        if (s_q.bit_idx == '0) begin
          s_d.st = DCA_DONE;
        end else begin
          s_d.bit_idx = s_q.bit_idx - 5'h01;
          s_d.sar[s_q.bit_idx - 5'h01] = 1'b1;
        end
      end
      DCA_DONE: begin
        // offset binary to two's complement by flipping msb
        s_d.res = (s_q.sar + i_corr) ^ {1'b1, {(RES_W-1){1'b0}}}; // [RQ6] [RQ8]
        s_d.done = 1'b1;
        s_d.st = DCA_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      s_q <= '{st: DCA_IDLE, sar: '0, bit_idx: '0, res: '0, done: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end
endmodule
`default_nettype wire

/* rtl/dca_top.sv */
// converter control: sample timing, two sar channels, serial output
`default_nettype none
module dca_top
  import dca_pkg::*;
#(
  parameter logic [RES_W-1:0] CORR_CH1 = CORR_DEFAULT, // arbitrary
  parameter logic [RES_W-1:0] CORR_CH2 = CORR_DEFAULT  // arbitrary
)(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // host controls, synchronous to i_mclk
  input wire logic i_convert_clock,
  input wire logic i_channel_phase_select,
  input wire logic i_word_width_select,
  // comparator decisions from the analog front end
  input wire logic i_cmp_hi_ch1,
  input wire logic i_cmp_hi_ch2,
  // analog front end control
  output logic o_sample_hold,
  output logic [RES_W-1:0] o_trial_ch1,
  output logic [RES_W-1:0] o_trial_ch2,
  // serial output
  output logic o_serial_data
);
  typedef struct packed {
    logic convert_clock_prev;
    logic sh;
    logic [RES_W-1:0] hold1;
    logic [RES_W-1:0] hold2;
    logic [RES_W-1:0] snd1;
    logic [RES_W-1:0] snd2;
    logic [RES_W-1:0] shreg;
    logic [CNT_W-1:0] left;
    logic busy;
    logic dout;
  } dca_top_st_t;
  dca_top_st_t s_q, s_d;

  logic done1, done2;
  logic [RES_W-1:0] res1, res2;
  logic convert_clock_edge;

  // one decode used for both load points
  function automatic logic [RES_W-1:0] pick_word(
    input logic convert_clock_lvl, input logic phase_sel,
    input logic [RES_W-1:0] r1, input logic [RES_W-1:0] r2);
    // phase high: channel 1 while convert is low
    pick_word = ((convert_clock_lvl == 1'b0) == phase_sel) ? r1 : r2; // [RQ12]
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // shared sample pulse on each rising convert edge starts both channels
  assign convert_clock_edge = i_convert_clock ^ s_q.convert_clock_prev; // [RQ2] [RQ9]
  assign o_sample_hold = s_q.sh;

  // both channels start from the same sample pulse [RQ1]
  dca_sar u_sar1 (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_start(s_q.sh),
    .i_cmp_hi(i_cmp_hi_ch1), .i_corr(CORR_CH1), .o_trial(o_trial_ch1),
    .o_done(done1), .o_result(res1));
  dca_sar u_sar2 (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_start(s_q.sh),
    .i_cmp_hi(i_cmp_hi_ch2), .i_corr(CORR_CH2), .o_trial(o_trial_ch2),
    .o_done(done2), .o_result(res2));

  //////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_d = s_q;
    s_d.convert_clock_prev = i_convert_clock;
    // sample once per period, on the rising convert edge only
    s_d.sh = convert_clock_edge && i_convert_clock; // [RQ1]
    // results wait in holding words until the next period starts
    if (done1) begin
      s_d.hold1 = res1;
    end
    if (done2) begin
      s_d.hold2 = res2;
    end
    if (convert_clock_edge) begin
      // each phase of the next period sends one word [RQ11]
      if (i_convert_clock) begin
        // rising edge: last period's results move to the send pair, so
        // the conversion now starting cannot replace the falling word
        s_d.snd1 = s_q.hold1; // [RQ11]
        s_d.snd2 = s_q.hold2; // [RQ11]
        s_d.shreg = pick_word(i_convert_clock, i_channel_phase_select,
                              s_q.hold1, s_q.hold2); // [RQ7]
      end else begin
        s_d.shreg = pick_word(i_convert_clock, i_channel_phase_select,
                              s_q.snd1, s_q.snd2); // [RQ7] [RQ11]
      end
      s_d.left = i_word_width_select ? RES_LAST : NARROW_LAST; // [RQ13]
      s_d.busy = 1'b1;
    end else if (s_q.busy) begin
      // msb first, one bit each clock, word ends ahead of the next edge
      s_d.dout = s_q.shreg[RES_W-1]; // [RQ15] [RQ14]
      s_d.shreg = {s_q.shreg[RES_W-2:0], 1'b0};
      if (s_q.left == '0) begin
        s_d.busy = 1'b0;
      end else begin
        s_d.left = s_q.left - 5'h01;
      end
    end else begin
      s_d.dout = 1'b0;
    end
  end

  // 16-bit mode sends the top 16 bits of the two's complement word [RQ13]
  assign o_serial_data = s_q.dout;

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      s_q <= '{convert_clock_prev: 1'b0, sh: 1'b0, hold1: CORR_RST, hold2: CORR_RST,
               snd1: CORR_RST, snd2: CORR_RST,
               shreg: '0, left: '0, busy: 1'b0, dout: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end
  // conversion spans 21 clocks inside the 32-clock high half, so a
  // 64-clock convert period always covers it [RQ4]
endmodule
`default_nettype wire

/* sim/dca_front_model.sv */
// analog front end model: sample hold and two comparators
`default_nettype none
module dca_front_model
  import dca_pkg::*;
(
  input wire logic i_sh,
  input wire logic [RES_W-1:0] i_vin1, i_vin2, i_trial1, i_trial2,
  output logic o_cmp1,
  output logic o_cmp2
);
  logic [RES_W-1:0] held1, held2;
  // both inputs held by the same pulse, so no skew between them
  always_latch begin
    if (i_sh) begin
      held1 = i_vin1;
      held2 = i_vin2;
    end
  end
  // keep the trial bit while the trial stays at or below the level
  assign o_cmp1 = i_trial1 <= held1;
  assign o_cmp2 = i_trial2 <= held2;
endmodule
`default_nettype wire

/* sim/dca_top_properties.sv */
// timing checks on the converter control ports
`default_nettype none
module dca_top_properties
  import dca_pkg::*;
(
  input wire logic i_mclk, i_rst, i_convert_clock,
  input wire logic o_sample_hold, o_serial_data,
  input wire logic [RES_W-1:0] o_trial_ch1, o_trial_ch2
);
  logic prev_q;
  logic [5:0] cnt_q;
  // cycles since the last convert edge, saturating
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      prev_q <= 1'b0;
      cnt_q <= 6'h3f;
    end else begin
      prev_q <= i_convert_clock;
      if (prev_q != i_convert_clock) cnt_q <= 6'h00;
      else if (cnt_q != 6'h3f) cnt_q <= cnt_q + 6'h01;
    end
  end
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  sequence s_rise; !i_convert_clock ##1 i_convert_clock; endsequence
  property p_sh_rise; s_rise |=> o_sample_hold; endproperty
  a_sh_rise: assert property (p_sh_rise)
    else $error("no sample pulse after rising edge");
  property p_sh_only;
    o_sample_hold |-> $past(i_convert_clock) && !$past(i_convert_clock, 2);
  endproperty
  a_sh_only: assert property (p_sh_only)
    else $error("sample pulse without rising edge");
  property p_sh_once; o_sample_hold |=> !o_sample_hold [*8]; endproperty
  a_sh_once: assert property (p_sh_once)
    else $error("sample pulse repeated");
  property p_trial_go;
    o_sample_hold |-> ##[0:3]
      (o_trial_ch1 == 18'h20000 && o_trial_ch2 == 18'h20000);
  endproperty
  a_trial_go: assert property (p_trial_go)
    else $error("trial does not start at msb");
  property p_trial1_hold; cnt_q >= 6'h18 |-> $stable(o_trial_ch1); endproperty
  a_trial1_hold: assert property (p_trial1_hold)
    else $error("channel 1 conversion too long");
  property p_trial2_hold; cnt_q >= 6'h18 |-> $stable(o_trial_ch2); endproperty
  a_trial2_hold: assert property (p_trial2_hold)
    else $error("channel 2 conversion too long");
  property p_tail; cnt_q >= 6'h15 |-> !o_serial_data; endproperty
  a_tail: assert property (p_tail)
    else $error("serial bits after word end");
  property p_lead; $changed(i_convert_clock) |=> !o_serial_data; endproperty
  a_lead: assert property (p_lead)
    else $error("serial line busy at convert edge");
endmodule
bind dca_top dca_top_properties i_chk (.i_mclk, .i_rst, .i_convert_clock,
  .o_sample_hold, .o_serial_data, .o_trial_ch1, .o_trial_ch2);
`default_nettype wire

/* sim/test_dca_top.sv */
// random and corner stimulus for the converter control block
`default_nettype none
module test_dca_top;
  timeunit 1ns;
  timeprecision 1ns;
  import dca_pkg::*;
  localparam logic [RES_W-1:0] C1 = 18'h00123, C2 = 18'h00456;
  logic i_mclk = 0, i_rst = 1, convert_clock = 0, phs = 0, wid = 0;
  logic cmp1, cmp2, sh, sdo;
  logic [RES_W-1:0] tr1, tr2, v1 = 0, v2 = 0, e1, e2, got;
  logic [31:0] rnd = 92516;
  int n_errors = 0, checked = 0, cyc = 0, p;
  always #4 i_mclk = ~i_mclk; // time scaled, rate set by 64-clock period
  dca_top #(.CORR_CH1(C1), .CORR_CH2(C2)) i_dut (.i_mclk, .i_rst,
    .i_convert_clock(convert_clock), .i_channel_phase_select(phs),
    .i_word_width_select(wid), .i_cmp_hi_ch1(cmp1), .i_cmp_hi_ch2(cmp2),
    .o_sample_hold(sh), .o_trial_ch1(tr1), .o_trial_ch2(tr2),
    .o_serial_data(sdo));
  dca_front_model i_afe (.i_sh(sh), .i_vin1(v1), .i_vin2(v2),
    .i_trial1(tr1), .i_trial2(tr2), .o_cmp1(cmp1), .o_cmp2(cmp2));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // corrected sum, msb flipped for two's complement
  function automatic logic [RES_W-1:0] code(input logic [RES_W-1:0] v, c);
    return (v + c) ^ 18'h20000;
  endfunction
  task automatic check(input logic [RES_W-1:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    if (n_errors == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  // one convert half: drive the edge, gather the word, compare
  task automatic half(input logic lvl);
    logic w, s;
    logic [RES_W-1:0] ex;
    w = lvl ? rnd[3] : rnd[4];
    s = lvl ? rnd[5] : phs; // select moves only on rising edges
    got = '0;
    convert_clock <= lvl; // 32 clocks a half
    wid <= w;
    phs <= s;
    for (int j = 0; j < 32; j++) begin
      // look mid-cycle, where the bit launched at edge j has settled
      @(negedge i_mclk);
      if (j >= 2 && j <= (w ? 19 : 17)) got = {got[16:0], sdo};
      @(posedge i_mclk);
    end
    ex = (s != lvl) ? e1 : e2;
    if (!w) ex = {2'h0, ex[17:2]};
    if (p > 1) check(got, ex);
  endtask
  // hang guard, about three times the planned run
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc > 20000) begin
      n_errors++;
      wrap_up();
    end
  end
  initial begin
    repeat (10) @(posedge i_mclk);
    i_rst <= 0;
    for (p = 0; p < 100; p++) begin
      rnd = lfsr(rnd);
      e1 = code(v1, C1); // held in the period before
      e2 = code(v2, C2);
      v1 <= (p == 1) ? 18'h00000 : rnd[17:0] & 18'h3efff;
      v2 <= (p == 1) ? 18'h3efff : rnd[31:14] & 18'h3efff;
      half(1'b1);
      half(1'b0);
    end
    wrap_up();
  end
endmodule
`default_nettype wire
